/* rtl/dpbr_top.sv */
// Dual-port synchronous block memory with parity and output latches
//
// What this block does
// - Every read and write is synchronous to the clock and the two ports act independently.
// - Enable, write enable and output reset are active high on the rising edge; enable low changes nothing unless global set/reset is high or reset_n_i is low.
// - Enable and write enable high store the write data and parity at the address given in that cycle.
// - The 16384-bit data array is preloaded from strings of 32 hex values each.
// - The 2048-bit parity array is preloaded from its own strings of 32 hex values each.
// - While global set/reset is high each port shows its start value and memory is untouched.
// - Each port has its own output reset value as wide as the port.
// - Enable with output reset loads the reset value, and a write in that cycle still happens.
// - Enable without reset or write shows the stored word and parity at the address.
// - A write without reset shows new data, old data or no change by the port's write mode.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "dpbr_params.svh"
`timescale 1ns/10ps
`default_nettype none

module dpbr_top #(
  parameter int                             A_W        = 32,
  parameter int                             B_W        = 32,
  parameter dpbr_pkg::dpbr_wmode_e          A_MODE     = dpbr_pkg::DPBR_WRITE_FIRST,
  parameter dpbr_pkg::dpbr_wmode_e          B_MODE     = dpbr_pkg::DPBR_WRITE_FIRST,
  parameter logic [A_W+A_W/8-1:0]           PORT_A_LATCH_START_VALUE = '0,
  parameter logic [B_W+B_W/8-1:0]           PORT_B_LATCH_START_VALUE = '0,
  parameter logic [A_W+A_W/8-1:0]           PORT_A_LATCH_RESET_VALUE = '0,
  parameter logic [B_W+B_W/8-1:0]           PORT_B_LATCH_RESET_VALUE = '0,
  parameter logic [`DPBR_DATA_BITS-1:0]     DATA_PRELOAD_STRING      = '0,
  parameter logic [`DPBR_PARITY_BITS-1:0]   PARITY_PRELOAD_STRING    = '0
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         global_set_reset_i,
  input  wire dpbr_pkg::dpbr_port_req_s     port_a_req_i,
  input  wire dpbr_pkg::dpbr_port_req_s     port_b_req_i,
  output logic [A_W-1:0]                    read_data_out_a_o,
  output logic [A_W/8-1:0]                  read_parity_out_a_o,
  output logic [B_W-1:0]                    read_data_out_b_o,
  output logic [B_W/8-1:0]                  read_parity_out_b_o
);

  localparam int A_BYTES      = A_W / `DPBR_BYTE_BITS;
  localparam int B_BYTES      = B_W / `DPBR_BYTE_BITS;
  localparam int A_DEPTH      = `DPBR_BYTES / A_BYTES;
  localparam int B_DEPTH      = `DPBR_BYTES / B_BYTES;
  localparam int STRING_BYTES = `DPBR_STRING_BITS / `DPBR_BYTE_BITS;

  // Byte lanes keep mixed port widths on one shared array
  if (!(A_W inside {8, 16, 32}) || !(B_W inside {8, 16, 32})) begin : g_width_check
    $error("dpbr_top: port width must be 8, 16 or 32");
  end

  // The request carrier limits the widest word and the deepest address
  if (A_W > `DPBR_MAX_W || B_W > `DPBR_MAX_W) begin : g_carrier_check
    $error("dpbr_top: port width exceeds the request carrier");
  end

  if (A_DEPTH > (1 << `DPBR_ADDR_W) || B_DEPTH > (1 << `DPBR_ADDR_W)) begin : g_depth_check
    $error("dpbr_top: port depth exceeds the address field");
  end

  // Width times depth must cover both arrays, or words would alias
  if (A_DEPTH * A_W != `DPBR_DATA_BITS ||
      B_DEPTH * B_W != `DPBR_DATA_BITS) begin : g_data_cover
    $error("dpbr_top: port shape does not cover the data array");
  end

  if (A_DEPTH * A_BYTES != `DPBR_PARITY_BITS ||
      B_DEPTH * B_BYTES != `DPBR_PARITY_BITS) begin : g_parity_cover
    $error("dpbr_top: port shape does not cover the parity array");
  end

  // Preload strings must tile the arrays with nothing left over
  if (`DPBR_HEX_PER_STRING * 4 != `DPBR_STRING_BITS ||
      `DPBR_DATA_STRINGS * `DPBR_STRING_BITS != `DPBR_DATA_BITS ||
      `DPBR_PARITY_STRINGS * `DPBR_STRING_BITS != `DPBR_PARITY_BITS) begin : g_string_check
    $error("dpbr_top: preload strings do not tile the arrays");
  end

  // An out-of-range mode code would silently act as no-change
  if (!(A_MODE inside {dpbr_pkg::DPBR_WRITE_FIRST, dpbr_pkg::DPBR_READ_FIRST,
                       dpbr_pkg::DPBR_NO_CHANGE}) ||
      !(B_MODE inside {dpbr_pkg::DPBR_WRITE_FIRST, dpbr_pkg::DPBR_READ_FIRST,
                       dpbr_pkg::DPBR_NO_CHANGE})) begin : g_mode_check
    $error("dpbr_top: unknown write mode");
  end

  typedef logic [`DPBR_BYTE_BITS-1:0] dpbr_byte_array_t [0:`DPBR_BYTES-1];
  typedef logic                       dpbr_bit_array_t  [0:`DPBR_BYTES-1];

  // Address wraps at the port depth, then lanes are consecutive bytes
  function automatic logic [`DPBR_BYTE_IDX_W-1:0] byte_idx(
    input logic [`DPBR_ADDR_W-1:0] addr,
    input int                      depth,
    input int                      bytes,
    input int                      lane
  );
    int idx;
    idx = (int'(addr) % depth) * bytes + lane;
    return idx[`DPBR_BYTE_IDX_W-1:0];
  endfunction : byte_idx

  // Data strings are 128-bit slices of the preload vector, lowest byte first
  function automatic dpbr_byte_array_t preload_data();
    dpbr_byte_array_t             mem;
    logic [`DPBR_STRING_BITS-1:0] data_preload_string;
    for (int s = 0; s < `DPBR_DATA_STRINGS; s++) begin
      data_preload_string =
        DATA_PRELOAD_STRING[s*`DPBR_STRING_BITS +: `DPBR_STRING_BITS];
      for (int b = 0; b < STRING_BYTES; b++) begin
        mem[s*STRING_BYTES+b] = data_preload_string[b*`DPBR_BYTE_BITS +: `DPBR_BYTE_BITS];
      end
    end
    return mem;
  endfunction : preload_data

  // Parity strings carry one bit for each data byte
  function automatic dpbr_bit_array_t preload_parity();
    dpbr_bit_array_t              mem;
    logic [`DPBR_STRING_BITS-1:0] parity_preload_string;
    for (int s = 0; s < `DPBR_PARITY_STRINGS; s++) begin
      parity_preload_string =
        PARITY_PRELOAD_STRING[s*`DPBR_STRING_BITS +: `DPBR_STRING_BITS];
      for (int b = 0; b < `DPBR_STRING_BITS; b++) begin
        mem[s*`DPBR_STRING_BITS+b] = parity_preload_string[b];
      end
    end
    return mem;
  endfunction : preload_parity

  // Preload by declaration keeps the write processes the only drivers
  dpbr_byte_array_t data_mem   = preload_data();
  dpbr_bit_array_t  parity_mem = preload_parity();

  // Byte indices of each port's lanes, shared by its read and write paths
  logic [`DPBR_BYTE_IDX_W-1:0] lane_idx_a [A_BYTES];
  logic [`DPBR_BYTE_IDX_W-1:0] lane_idx_b [B_BYTES];

  always_comb begin
    for (int k = 0; k < A_BYTES; k++) begin
      lane_idx_a[k] = byte_idx(port_a_req_i.addr, A_DEPTH, A_BYTES, k);
    end
  end

  always_comb begin
    for (int k = 0; k < B_BYTES; k++) begin
      lane_idx_b[k] = byte_idx(port_b_req_i.addr, B_DEPTH, B_BYTES, k);
    end
  end

  // Global set/reset blocks writes; output reset does not
  logic wr_a;
  logic wr_b;

  always_comb begin
    wr_a = port_a_req_i.en && port_a_req_i.we && !global_set_reset_i;
    wr_b = port_b_req_i.en && port_b_req_i.we && !global_set_reset_i;
  end

  // Port B is applied after port A, so B wins a same-byte collision
  always_ff @(posedge ref_clk_i) begin
    if (wr_a) begin
      for (int k = 0; k < A_BYTES; k++) begin
        data_mem[lane_idx_a[k]] <=
          port_a_req_i.write_data_in[k*`DPBR_BYTE_BITS +: `DPBR_BYTE_BITS];
      end
    end
    if (wr_b) begin
      for (int k = 0; k < B_BYTES; k++) begin
        data_mem[lane_idx_b[k]] <=
          port_b_req_i.write_data_in[k*`DPBR_BYTE_BITS +: `DPBR_BYTE_BITS];
      end
    end
  end

  // Parity bits follow their data bytes lane for lane
  always_ff @(posedge ref_clk_i) begin
    if (wr_a) begin
      for (int k = 0; k < A_BYTES; k++) begin
        parity_mem[lane_idx_a[k]] <= port_a_req_i.write_parity_in[k];
      end
    end
    if (wr_b) begin
      for (int k = 0; k < B_BYTES; k++) begin
        parity_mem[lane_idx_b[k]] <= port_b_req_i.write_parity_in[k];
      end
    end
  end

  // Stored words are read before this edge's write lands
  logic [A_W+A_BYTES-1:0] stored_a;
  logic [A_W+A_BYTES-1:0] written_a;
  logic [B_W+B_BYTES-1:0] stored_b;
  logic [B_W+B_BYTES-1:0] written_b;

  always_comb begin
    stored_a = '0;
    for (int k = 0; k < A_BYTES; k++) begin
      stored_a[k*`DPBR_BYTE_BITS +: `DPBR_BYTE_BITS] = data_mem[lane_idx_a[k]];
      stored_a[A_W+k]                                = parity_mem[lane_idx_a[k]];
    end
  end

  always_comb begin
    written_a[A_W-1:0]           = port_a_req_i.write_data_in[A_W-1:0];
    written_a[A_W+A_BYTES-1:A_W] = port_a_req_i.write_parity_in[A_BYTES-1:0];
  end

  always_comb begin
    stored_b = '0;
    for (int k = 0; k < B_BYTES; k++) begin
      stored_b[k*`DPBR_BYTE_BITS +: `DPBR_BYTE_BITS] = data_mem[lane_idx_b[k]];
      stored_b[B_W+k]                                = parity_mem[lane_idx_b[k]];
    end
  end

  always_comb begin
    written_b[B_W-1:0]           = port_b_req_i.write_data_in[B_W-1:0];
    written_b[B_W+B_BYTES-1:B_W] = port_b_req_i.write_parity_in[B_BYTES-1:0];
  end

  logic [A_W+A_BYTES-1:0] latch_a;
  logic [B_W+B_BYTES-1:0] latch_b;

  dpbr_out_latch #(
    .W      (A_W),
    .PW     (A_BYTES),
    .START  (PORT_A_LATCH_START_VALUE),
    .RSTVAL (PORT_A_LATCH_RESET_VALUE),
    .MODE   (A_MODE)
  ) u_latch_a (
    .ref_clk_i           (ref_clk_i),
    .reset_n_i           (reset_n_i),
    .global_set_reset_i  (global_set_reset_i),
    .en_i                (port_a_req_i.en),
    .we_i                (port_a_req_i.we),
    .sync_output_reset_i (port_a_req_i.sync_output_reset),
    .stored_i            (stored_a),
    .written_i           (written_a),
    .latch_o             (latch_a)
  );

  dpbr_out_latch #(
    .W      (B_W),
    .PW     (B_BYTES),
    .START  (PORT_B_LATCH_START_VALUE),
    .RSTVAL (PORT_B_LATCH_RESET_VALUE),
    .MODE   (B_MODE)
  ) u_latch_b (
    .ref_clk_i           (ref_clk_i),
    .reset_n_i           (reset_n_i),
    .global_set_reset_i  (global_set_reset_i),
    .en_i                (port_b_req_i.en),
    .we_i                (port_b_req_i.we),
    .sync_output_reset_i (port_b_req_i.sync_output_reset),
    .stored_i            (stored_b),
    .written_i           (written_b),
    .latch_o             (latch_b)
  );

  assign read_data_out_a_o   = latch_a[A_W-1:0];
  assign read_parity_out_a_o = latch_a[A_W+A_BYTES-1:A_W];
  assign read_data_out_b_o   = latch_b[B_W-1:0];
  assign read_parity_out_b_o = latch_b[B_W+B_BYTES-1:B_W];

endmodule : dpbr_top

`default_nettype wire

/* rtl/dpbr_params.svh */
// Constants of the dual-port block memory
`ifndef DPBR_PARAMS_SVH
`define DPBR_PARAMS_SVH

`define DPBR_DATA_BITS      16384
`define DPBR_PARITY_BITS    2048
`define DPBR_BYTE_BITS      8
`define DPBR_BYTES          2048
`define DPBR_BYTE_IDX_W     11
`define DPBR_MAX_W          32
`define DPBR_MAX_PW         4
`define DPBR_ADDR_W         11
`define DPBR_HEX_PER_STRING 32
`define DPBR_STRING_BITS    128
`define DPBR_DATA_STRINGS   128
`define DPBR_PARITY_STRINGS 16

`endif

/* rtl/dpbr_pkg.sv */
// Types shared by the dual-port block memory files
`include "dpbr_params.svh"

package dpbr_pkg;

  typedef enum logic [1:0] {
    DPBR_WRITE_FIRST,
    DPBR_READ_FIRST,
    DPBR_NO_CHANGE
  } dpbr_wmode_e;

  typedef struct packed {
    logic                          en;
    logic                          we;
    logic                          sync_output_reset;
    logic [`DPBR_ADDR_W-1:0]       addr;
    logic [`DPBR_MAX_W-1:0]        write_data_in;
    logic [`DPBR_MAX_PW-1:0]       write_parity_in;
  } dpbr_port_req_s;

endpackage : dpbr_pkg

/* rtl/dpbr_out_latch.sv */
// Output latch of one memory port
`timescale 1ns/10ps
`default_nettype none

module dpbr_out_latch #(
  parameter int                  W       = 32,
  parameter int                  PW      = 4,
  parameter logic [W+PW-1:0]     START   = '0,
  parameter logic [W+PW-1:0]     RSTVAL  = '0,
  parameter dpbr_pkg::dpbr_wmode_e MODE  = dpbr_pkg::DPBR_WRITE_FIRST
) (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              global_set_reset_i,
  input  wire logic              en_i,
  input  wire logic              we_i,
  input  wire logic              sync_output_reset_i,
  input  wire logic [W+PW-1:0]   stored_i,
  input  wire logic [W+PW-1:0]   written_i,
  output logic      [W+PW-1:0]   latch_o
);

  logic [W+PW-1:0] latch_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || global_set_reset_i) begin
      latch_reg <= START;
    end else if (en_i) begin
      if (sync_output_reset_i) begin
        latch_reg <= RSTVAL;
      end else if (!we_i) begin
        latch_reg <= stored_i;
      end else begin
        case (MODE)
          dpbr_pkg::DPBR_WRITE_FIRST: latch_reg <= written_i;
          dpbr_pkg::DPBR_READ_FIRST:  latch_reg <= stored_i;
          default:                    latch_reg <= latch_reg;
        endcase
      end
    end
  end

  assign latch_o = latch_reg;

endmodule : dpbr_out_latch

`default_nettype wire

/* tb/dpbr_checker.sv */
// Port assertions for the dual-port block memory
`timescale 1ns/10ps
`default_nettype none
module dpbr_checker #(
  parameter int                    A_W    = 32,
  parameter int                    B_W    = 32,
  parameter dpbr_pkg::dpbr_wmode_e A_MODE = dpbr_pkg::DPBR_WRITE_FIRST,
  parameter dpbr_pkg::dpbr_wmode_e B_MODE = dpbr_pkg::DPBR_WRITE_FIRST,
  parameter logic [A_W+A_W/8-1:0]  PORT_A_LATCH_START_VALUE = '0,
  parameter logic [B_W+B_W/8-1:0]  PORT_B_LATCH_START_VALUE = '0,
  parameter logic [A_W+A_W/8-1:0]  PORT_A_LATCH_RESET_VALUE = '0,
  parameter logic [B_W+B_W/8-1:0]  PORT_B_LATCH_RESET_VALUE = '0
) (
  input wire logic                     ref_clk_i,
  input wire logic                     reset_n_i,
  input wire logic                     global_set_reset_i,
  input wire dpbr_pkg::dpbr_port_req_s port_a_req_i,
  input wire dpbr_pkg::dpbr_port_req_s port_b_req_i,
  input wire logic [A_W-1:0]           read_data_out_a_o,
  input wire logic [A_W/8-1:0]         read_parity_out_a_o,
  input wire logic [B_W-1:0]           read_data_out_b_o,
  input wire logic [B_W/8-1:0]         read_parity_out_b_o
);
  wire logic [A_W+A_W/8-1:0] qa = {read_parity_out_a_o, read_data_out_a_o};
  wire logic [B_W+B_W/8-1:0] qb = {read_parity_out_b_o, read_data_out_b_o};
  wire logic                 ga = port_a_req_i.en && !global_set_reset_i;
  wire logic                 gb = port_b_req_i.en && !global_set_reset_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_gsr_start_a: assert property (global_set_reset_i |=> qa == PORT_A_LATCH_START_VALUE)
    else $error("port a start value missing");
  a_gsr_start_b: assert property (global_set_reset_i |=> qb == PORT_B_LATCH_START_VALUE)
    else $error("port b start value missing");
  a_ssr_load_a: assert property (ga && port_a_req_i.sync_output_reset
    |=> qa == PORT_A_LATCH_RESET_VALUE) else $error("port a reset value missing");
  a_ssr_load_b: assert property (gb && port_b_req_i.sync_output_reset
    |=> qb == PORT_B_LATCH_RESET_VALUE) else $error("port b reset value missing");
  a_idle_hold_a: assert property (!global_set_reset_i && !port_a_req_i.en |=> $stable(qa))
    else $error("port a changed while disabled");
  a_idle_hold_b: assert property (!global_set_reset_i && !port_b_req_i.en |=> $stable(qb))
    else $error("port b changed while disabled");
  a_new_data_a: assert property ((A_MODE == dpbr_pkg::DPBR_WRITE_FIRST) && ga
    && port_a_req_i.we && !port_a_req_i.sync_output_reset
    |=> read_data_out_a_o == $past(port_a_req_i.write_data_in[A_W-1:0]))
    else $error("port a did not show written data");
  a_keep_prior_b: assert property ((B_MODE == dpbr_pkg::DPBR_NO_CHANGE) && gb
    && port_b_req_i.we && !port_b_req_i.sync_output_reset |=> $stable(qb))
    else $error("port b changed during write");
endmodule : dpbr_checker
`default_nettype wire

/* tb/dpbr_user_model.sv */
// User logic that drives one memory port
`timescale 1ns/10ps
`default_nettype none
module dpbr_user_model (
  input  wire logic                ref_clk_i,
  output dpbr_pkg::dpbr_port_req_s req_o
);
  initial req_o = '0;
  // Address and data change only after an edge and hold until the next op
  task automatic op(input logic [2:0] c, input logic [10:0] ad, input logic [35:0] w);
    @(posedge ref_clk_i);
    req_o <= '{c[2], c[1], c[0], ad, w[31:0], w[35:32]};
  endtask : op
endmodule : dpbr_user_model
`default_nettype wire

/* tb/dpbr_top_tb.sv */
// Testbench of the dual-port block memory
`timescale 1ns/10ps
`default_nettype none
module dpbr_top_tb;
  localparam logic [2:0] I = 3'b000, R = 3'b100, W = 3'b110, S = 3'b101;
  localparam logic [35:0] SA = 36'h555555555, RA = 36'hAAAAAAAAA;
  localparam logic [35:0] X1 = 36'h1CAFE0001, X2 = 36'hE0BAD0002, X3 = 36'h712345678;
  logic                     ref_clk_i, reset_n_i, global_set_reset_i;
  dpbr_pkg::dpbr_port_req_s ra, rb;
  logic [31:0]              da1, da2;
  logic [3:0]               pa1, pa2;
  logic [15:0]              db1;
  logic [1:0]               pb1;
  int                       failures, tests_run;
  dpbr_user_model user_a (.ref_clk_i, .req_o(ra));
  dpbr_user_model user_b (.ref_clk_i, .req_o(rb));
  dpbr_top #(.B_W(16), .B_MODE(dpbr_pkg::DPBR_NO_CHANGE),
    .PORT_A_LATCH_START_VALUE(SA), .PORT_B_LATCH_START_VALUE(18'h15555),
    .PORT_A_LATCH_RESET_VALUE(RA), .PORT_B_LATCH_RESET_VALUE(18'h2AAAA),
    .DATA_PRELOAD_STRING(16384'hC3A50F1E), .PARITY_PRELOAD_STRING(2048'h9)) dpbr_top_i (
    .ref_clk_i, .reset_n_i, .global_set_reset_i, .port_a_req_i(ra), .port_b_req_i(rb),
    .read_data_out_a_o(da1), .read_parity_out_a_o(pa1),
    .read_data_out_b_o(db1), .read_parity_out_b_o(pb1));
  // Read-first twin shares port A traffic so both modes see identical writes
  dpbr_top #(.A_MODE(dpbr_pkg::DPBR_READ_FIRST)) dpbr_top_rf_i (
    .ref_clk_i, .reset_n_i, .global_set_reset_i, .port_a_req_i(ra), .port_b_req_i(rb),
    .read_data_out_a_o(da2), .read_parity_out_a_o(pa2),
    .read_data_out_b_o(), .read_parity_out_b_o());
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic go(input logic [2:0] ca, input logic [10:0] aa, input logic [35:0] wa,
                    input logic [2:0] cb, input logic [10:0] ab, input logic [35:0] wb);
    fork
      user_a.op(ca, aa, wa);
      user_b.op(cb, ab, wb);
    join
  endtask : go
  task automatic idle;
    go(I, 0, 0, I, 0, 0);
    #1;
  endtask : idle
  task automatic t_gsr;
    chk({pa1, da1}, SA);
    chk({18'h0, pb1, db1}, 36'h15555);
    @(posedge ref_clk_i) global_set_reset_i <= 1'b1;
    go(W, 2, X3, I, 0, 0);
    idle();
    chk({pa1, da1}, SA);
    @(posedge ref_clk_i) global_set_reset_i <= 1'b0;
    go(R, 2, 0, I, 0, 0);
    idle();
    chk({pa1, da1}, 36'h0);
  endtask : t_gsr
  task automatic t_pre;
    go(R, 0, 0, I, 0, 0);
    idle();
    chk({pa1, da1}, 36'h9C3A50F1E);
  endtask : t_pre
  task automatic t_ssr;
    go(W | S, 3, X3, S, 11'h100, 0);
    idle();
    chk({pa1, da1}, RA);
    chk({18'h0, pb1, db1}, 36'h2AAAA);
    go(R, 3, 0, I, 0, 0);
    idle();
    chk({pa1, da1}, X3);
  endtask : t_ssr
  task automatic t_modes;
    go(W, 1, X1, W, 11'h100, 36'h30000BEEF);
    go(W, 1, X2, R, 11'h100, 0);
    #1;
    chk({pa1, da1}, X1);
    chk({pa2, da2}, 36'h0);
    chk({18'h0, pb1, db1}, 36'h2AAAA);
    idle();
    chk({pa1, da1}, X2);
    chk({pa2, da2}, X1);
    chk({18'h0, pb1, db1}, 36'h3BEEF);
  endtask : t_modes
  task automatic t_en;
    go(3'b010, 1, X3, I, 0, 0);
    idle();
    chk({pa1, da1}, X2);
    go(R, 1, 0, I, 0, 0);
    idle();
    chk({pa1, da1}, X2);
  endtask : t_en
  task automatic final_report;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    failures++;
    final_report();
  end
  initial begin
    failures = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    global_set_reset_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    t_gsr();
    t_pre();
    t_ssr();
    t_modes();
    t_en();
    final_report();
  end
endmodule : dpbr_top_tb
bind dpbr_top dpbr_checker #(.A_W(A_W), .B_W(B_W), .A_MODE(A_MODE), .B_MODE(B_MODE),
  .PORT_A_LATCH_START_VALUE(PORT_A_LATCH_START_VALUE),
  .PORT_B_LATCH_START_VALUE(PORT_B_LATCH_START_VALUE),
  .PORT_A_LATCH_RESET_VALUE(PORT_A_LATCH_RESET_VALUE),
  .PORT_B_LATCH_RESET_VALUE(PORT_B_LATCH_RESET_VALUE)) dpbr_checker_i (
  .ref_clk_i, .reset_n_i, .global_set_reset_i, .port_a_req_i, .port_b_req_i,
  .read_data_out_a_o, .read_parity_out_a_o, .read_data_out_b_o, .read_parity_out_b_o);
`default_nettype wire
